// >>> dv/sysref_clock_source.sv
// far-side model: periodic sysref, delayed tap samples and phase detector
`timescale 1ns/1ps
`default_nettype none
module sysref_clock_source #(
  parameter int PERIOD = 8,
  parameter int HALF   = 300,
  parameter int CSTEP  = 16
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  edge_pos,
  input  wire logic [11:0] target,
  input  wire logic        inv,
  input  wire logic [7:0]  coarse,
  input  wire logic [7:0]  fine,
  output logic             sysref,
  output logic [23:0]      tap_sample,
  output logic             phase_late
);
  int   cnt;
  logic rise;
  // sysref never stops, so the search always sees fresh edges
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt    <= 0;
      sysref <= 1'b0;
      rise   <= 1'b0;
    end else begin
      cnt    <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      sysref <= cnt < PERIOD / 2;
      rise   <= cnt == 0;
    end
  end
  // on the rise cycle only taps at or past edge_pos already see high
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      tap_sample[i] = rise ? (i >= int'(edge_pos)) : sysref;
    end
  end
  // late once the applied delay reaches the sysref edge
  assign phase_late = int'(inv) * HALF + int'(coarse) * CSTEP + int'(fine) >= int'(target);
endmodule
`default_nettype wire

// >>> dv/test_sysref_window_and_auto_align.sv
// self-checking bench for the sysref window and alignment block
`timescale 1ns/1ps
`default_nettype none
module test_sysref_window_and_auto_align
  import sysref_align_pkg::*;
;
  localparam int HALF_FU = 300;  // half period in fine steps
  localparam int STEP_FU = 16;   // one coarse step in fine steps
  logic             sys_clk, rst_b, sr_q, cap_on, s_axi_bready, s_axi_arvalid;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic             s_axi_arready, s_axi_rvalid, s_axi_rready, sysref, phase_late;
  logic             tap_step_fine, sysref_captured, clock_polarity_invert;
  logic [11:0]      s_axi_awaddr, s_axi_araddr, target;
  logic [31:0]      s_axi_wdata, s_axi_rdata, dly_pins;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic [MAP_W-1:0] tap_sample, tap_q;
  logic [SEL_W-1:0] capture_tap_select, sel_q;
  logic [DLY_W-1:0] aperture_delay_coarse, aperture_delay_fine;
  logic [4:0]       edge_pos;
  int               err_total, total_checks, seed;
  assign dly_pins = {15'h0, clock_polarity_invert, aperture_delay_coarse, aperture_delay_fine};
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  sysref_window_and_auto_align sysref_window_and_auto_align_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sysref(sysref), .tap_sample(tap_sample),
    .phase_late(phase_late), .tap_step_fine(tap_step_fine),
    .capture_tap_select(capture_tap_select), .sysref_captured(sysref_captured),
    .clock_polarity_invert(clock_polarity_invert), .aperture_delay_coarse(aperture_delay_coarse),
    .aperture_delay_fine(aperture_delay_fine));
  sysref_clock_source #(.HALF(HALF_FU), .CSTEP(STEP_FU)) sysref_clock_source_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .edge_pos(edge_pos), .target(target),
    .inv(clock_polarity_invert), .coarse(aperture_delay_coarse), .fine(aperture_delay_fine),
    .sysref(sysref), .tap_sample(tap_sample), .phase_late(phase_late));
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    err_total++;
    $display("[ERR] t=%0t timeout in %s", $time, what);
    tally_and_finish();
  endtask
  // register write: address and data offered together, each released when taken
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    if (n >= 100) hang("write");
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
  endtask
  // register read
  task automatic rd(input logic [9:0] idx, input logic [1:0] er, output logic [31:0] d);
    int n;
    n = 0;
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    if (n >= 100) hang("read");
    d = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
  endtask
  // wait for k sysref rises as the design samples them
  task automatic wait_rise(input int k);
    int n;
    n = 0;
    while (k > 0 && n < 1000) begin
      @(posedge sys_clk);
      n++;
      if (sysref && !sr_q) k--;
    end
    if (n >= 1000) hang("sysref");
  endtask
  // expected window map for a sysref edge between taps p-1 and p
  function automatic logic [23:0] exp_map(input int p);
    exp_map = 24'h800001;
    exp_map[p] = 1'b1;
    exp_map[p - 1] = 1'b1;
  endfunction
  // inverted polarity needs fewer coarse steps; back off one, then fine
  function automatic logic [16:0] exp_cal(input int t);
    int c;
    c = (t - HALF_FU + STEP_FU - 1) / STEP_FU - 1;
    exp_cal = {1'b1, 8'(c), 8'(t - HALF_FU - STEP_FU * c)};
  endfunction
  // captured output follows the selected tap one cycle later
  always @(posedge sys_clk) begin
    if (cap_on && sel_q === capture_tap_select) begin
      chk({31'h0, sysref_captured}, {31'h0, tap_q[sel_q]}, "capture");
    end
    tap_q <= tap_sample;
    sel_q <= capture_tap_select;
    sr_q  <= sysref;
  end
  // reset, refused access, window map, then calibration
  initial begin
    logic [31:0] d;
    logic [23:0] em;
    logic [16:0] ec;
    logic        z;
    int          p, s, t, n;
    seed = 32'hd32a429d;
    err_total = 0;
    total_checks = 0;
    rst_b = 1'b0;
    cap_on = 1'b0;
    edge_pos = 5'd2;
    target = 12'd400;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(IDX_CTRL, RESP_OKAY, d);
    chk(d, {27'h0, 1'b0, SEL_RST}, "ctrl reset");
    rd(IDX_TAD, RESP_OKAY, d);
    chk(d, {15'h0, TAD_RST}, "delay reset");
    rd(IDX_CAL_CFG, RESP_OKAY, d);
    chk(d, {24'h0, CFG_RST}, "config reset");
    rd(10'h3ff, RESP_SLVERR, d);
    chk(d, 32'h0, "unmapped read");
    wr(10'h3ff, 32'hffffffff, RESP_SLVERR);
    $display("test reset done");
    cap_on = 1'b1;
    for (int k = 0; k < 4; k++) begin
      p = (k == 0) ? 2 : (k == 1) ? 21 : 2 + int'($unsigned($random(seed)) % 20);
      s = (p <= 13) ? p + 2 : (p - 1) / 2;
      z = 1'($random(seed));
      em = exp_map(p);
      edge_pos <= 5'(p);
      wait_rise(1);
      wr(IDX_CTRL, {27'h0, z, 4'(s)}, RESP_OKAY);
      chk({27'h0, tap_step_fine, capture_tap_select}, {27'h0, z, 4'(s)}, "ctrl pins");
      wait_rise(2);
      rd(IDX_CAL_STAT, RESP_OKAY, d);
      chk({31'h0, d[STAT_VALID_BIT]}, 32'h0, "early valid");
      wait_rise(1);
      wr(IDX_MAP_LO, 32'h0000005a, RESP_SLVERR);
      rd(IDX_CAL_STAT, RESP_OKAY, d);
      chk({31'h0, d[STAT_VALID_BIT]}, 32'h1, "map valid");
      rd(IDX_MAP_LO, RESP_OKAY, d);
      chk(d, {24'h0, em[7:0]}, "map low");
      rd(IDX_MAP_MID, RESP_OKAY, d);
      chk(d, {24'h0, em[15:8]}, "map mid");
      rd(IDX_MAP_HI, RESP_OKAY, d);
      chk(d, {24'h0, em[23:16]}, "map high");
    end
    cap_on = 1'b0;
    $display("test window done");
    // converter calibration is never run by this bench while alignment runs
    for (int k = 0; k < 2; k++) begin
      t = 320 + int'($unsigned($random(seed)) % 1180);
      ec = exp_cal(t);
      target <= 12'(t);
      wr(IDX_CTRL, 32'h0, RESP_OKAY);
      wr(IDX_CAL_CFG, 32'(k), RESP_OKAY);
      wr(IDX_CAL_EN, 32'h1, RESP_OKAY);
      n = 0;
      d = 32'h0;
      while (!d[STAT_DONE_BIT] && n < 4000) begin
        rd(IDX_CAL_STAT, RESP_OKAY, d);
        n++;
      end
      if (n >= 4000) hang("calibration");
      chk({7'h0, d[24:0]}, {7'h0, 1'b1, 7'h0, ec}, "cal status");
      chk(dly_pins, {15'h0, ec}, "applied delay");
      wr(IDX_CAL_EN, 32'h0, RESP_OKAY);
      chk(dly_pins, {15'h0, ec}, "kept delay");
    end
    d = $random(seed);
    wr(IDX_TAD, d, RESP_OKAY);
    chk(dly_pins, {15'h0, d[16:0]}, "own delay");
    $display("test calibration done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> rtl/sysref_align_pkg.sv
// shared constants for the sysref window and alignment block
package sysref_align_pkg;
  localparam int MAP_W      = 24;  // candidate capture taps
  localparam int SEL_W      = 4;   // capture tap select width
  localparam int DLY_W      = 8;   // coarse and fine delay width
  localparam int EDGES_MIN  = 3;   // sysref edges before map is valid
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_CTRL     = 10'h029;
  localparam logic [9:0] IDX_TAD      = 10'h02a;
  localparam logic [9:0] IDX_MAP_LO   = 10'h02c;
  localparam logic [9:0] IDX_MAP_MID  = 10'h02d;
  localparam logic [9:0] IDX_MAP_HI   = 10'h02e;
  localparam logic [9:0] IDX_CAL_EN   = 10'h030;
  localparam logic [9:0] IDX_CAL_CFG  = 10'h031;
  localparam logic [9:0] IDX_CAL_STAT = 10'h032;
  // field positions
  localparam int CTRL_ZOOM_BIT  = 4;
  localparam int APERTURE_DELAY_COARSE_LSB = 8;
  localparam int CLOCK_POLARITY_INVERT_BIT    = 16;
  localparam int STAT_DONE_BIT  = 24;
  localparam int STAT_VALID_BIT = 25;
  // reset values, bus response codes and calibration states
  localparam logic [SEL_W-1:0] SEL_RST    = 4'h0;
  localparam logic [7:0]       CFG_RST    = 8'h02;
  localparam logic [16:0]      TAD_RST    = 17'h00000;
  localparam logic [1:0]       RESP_OKAY  = 2'b00;
  localparam logic [1:0]       RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {CAL_IDLE, CAL_COARSE, CAL_FINE, CAL_DONE} cal_state_t;
endpackage

// >>> rtl/sysref_window_and_auto_align.sv
// sysref capture window detector and automatic aperture alignment
// Summary of operation
// R1: measure sysref position inside the clock cycle into a readable tap bitmap
// R2: bitmap reported valid only after three sysref rising edges
// R3: bitmap bit is 1 where a tap risks setup or hold, else 0
// R4: 24 taps reported, capture select reaches only taps 0 to 15
// R5: bitmap bits 0 and 23 always read 1
// R6: select value is the tap index; sysref sampled on that tap
// R7: software picks a zero bit, ideally mid-run, as capture tap
// R8: zoom 0 gives coarse tap spacing, zoom 1 gives fine spacing
// R9: software uses zoom 1 above 3GHz clock, zoom 0 below
// R10: software keeps capture select at 0 during alignment calibration
// R11: clock, periodic sysref and normal setup present before calibration
// R12: software writes calibration config, then sets the enable bit
// R13: with enable set, search delays until clock falling edge meets sysref rise
// R14: search coarse delay at both polarities; keep the smaller coarse delay
// R15: on completion raise done and expose the found delay setting
// R16: calibrated delay stays applied until software disables and writes its own
// R17: software may later write stored invert, coarse and fine values
// R18: software keeps converter calibration off while alignment runs
// R19: invert adds half a period; coarse and fine each 256 steps, combined
// R20: bitmap packed over three byte registers, bit 0 smallest delay lowest
// R21: capture select four bits, values 0 to 15, reset 0
`timescale 1ns/1ps
`default_nettype none
module sysref_window_and_auto_align
  import sysref_align_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              sysref,
  input  wire logic [MAP_W-1:0]  tap_sample,
  input  wire logic              phase_late,
  output logic                   tap_step_fine,
  output logic [SEL_W-1:0]       capture_tap_select,
  output logic                   sysref_captured,
  output logic                   clock_polarity_invert,
  output logic [DLY_W-1:0]       aperture_delay_coarse,
  output logic [DLY_W-1:0]       aperture_delay_fine
);

  // ---------------- bus slave ----------------
  logic             aw_full_r;
  logic             w_full_r;
  logic [9:0]       aw_idx_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             bvalid_r;
  logic [1:0]       bresp_r;
  logic             rvalid_r;
  logic [31:0]      rdata_r;
  logic [1:0]       rresp_r;

  // software-visible state
  logic [SEL_W-1:0] sel_r;
  logic             zoom_r;
  logic [16:0]      tad_sw_r;
  logic             cal_en_r;
  logic [7:0]       cfg_r;

  wire       do_write  = aw_full_r && w_full_r && !bvalid_r;
  wire       do_read   = s_axi_arvalid && !rvalid_r;
  wire [9:0] ar_idx    = s_axi_araddr[11:2];
  wire       wr_ctrl   = do_write && aw_idx_r == IDX_CTRL && wstrb_r[0];
  wire       wr_tad    = do_write && aw_idx_r == IDX_TAD;
  wire       wr_en     = do_write && aw_idx_r == IDX_CAL_EN && wstrb_r[0];
  wire       wr_cfg    = do_write && aw_idx_r == IDX_CAL_CFG && wstrb_r[0];
  wire       wr_hit    = aw_idx_r == IDX_CTRL || aw_idx_r == IDX_TAD ||
                         aw_idx_r == IDX_CAL_EN || aw_idx_r == IDX_CAL_CFG;

  // handshake outputs
  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready  = !w_full_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // address and data may arrive in either order
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_idx_r  <= 10'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // software registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_r    <= SEL_RST;
      zoom_r   <= 1'b0;
      tad_sw_r <= TAD_RST;
      cal_en_r <= 1'b0;
      cfg_r    <= CFG_RST;
    end else begin
      if (wr_ctrl) begin
        sel_r  <= wdata_r[SEL_W-1:0];  // R21 R4
        zoom_r <= wdata_r[CTRL_ZOOM_BIT];
      end
      if (wr_tad && wstrb_r[0])
        tad_sw_r[7:0] <= wdata_r[7:0];
      if (wr_tad && wstrb_r[1])
        tad_sw_r[15:8] <= wdata_r[15:8];
      if (wr_tad && wstrb_r[2])
        tad_sw_r[16] <= wdata_r[CLOCK_POLARITY_INVERT_BIT];
      if (wr_en)
        cal_en_r <= wdata_r[0];
      if (wr_cfg)
        cfg_r <= wdata_r[7:0];
    end
  end

  // ---------------- window detector ----------------
  logic             sysref_d_r;
  logic [1:0]       edge_cnt_r;
  logic [MAP_W-1:0] acc_r;
  logic             captured_r;
  logic [MAP_W-1:0] viol;

  wire sysref_rise = sysref && !sysref_d_r;
  wire map_valid   = edge_cnt_r == 2'(EDGES_MIN);  // R2

  // a tap is marginal when either neighbour saw a different level
  genvar gi;
  generate
    for (gi = 1; gi < MAP_W-1; gi++) begin : g_viol
      assign viol[gi] = (tap_sample[gi] != tap_sample[gi-1]) ||
                        (tap_sample[gi] != tap_sample[gi+1]);  // R3
    end
  endgenerate
  assign viol[0]       = 1'b1;
  assign viol[MAP_W-1] = 1'b1;

  wire [MAP_W-1:0] map = {1'b1, acc_r[MAP_W-2:1], 1'b1};  // R5 R1

  // accumulate violations per edge; a control register write with byte lane 0 strobed restarts the survey
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sysref_d_r <= 1'b0;
      edge_cnt_r <= 2'h0;
      acc_r      <= '0;
      captured_r <= 1'b0;
    end else begin
      sysref_d_r <= sysref;
      captured_r <= tap_sample[sel_r];  // R6
      if (wr_ctrl) begin
        // a rise landing on the restart is the first edge of the new survey
        edge_cnt_r <= {1'b0, sysref_rise};
        acc_r      <= sysref_rise ? viol : '0;  // R1 R3
      end else if (sysref_rise) begin
        acc_r <= acc_r | viol;  // R1 R3
        if (!map_valid)
          edge_cnt_r <= edge_cnt_r + 2'h1;
      end
    end
  end

  assign sysref_captured    = captured_r;
  assign capture_tap_select = sel_r;
  assign tap_step_fine      = zoom_r;  // R8

  // ---------------- alignment calibration ----------------
  cal_state_t       state_r;
  logic             inv_r;
  logic [DLY_W-1:0] coarse_r;
  logic [DLY_W-1:0] fine_r;
  logic [DLY_W-1:0] found_n_r;
  logic [7:0]       settle_r;
  logic             use_cal_r;
  logic             done_r;

  wire             settled  = settle_r == 8'h00;
  wire             step     = sysref_rise && settled;
  wire             hit      = step && phase_late;
  wire             top      = coarse_r == '1;
  // coarse at which the inverted pass crossed; start_c keeps one step short of the smaller of it and found_n_r, or 0 when that is 0
  wire [DLY_W-1:0] cross_i  = coarse_r;
  wire             pick_inv = cross_i < found_n_r;  // R14
  wire [DLY_W-1:0] best     = pick_inv ? cross_i : found_n_r;
  wire [DLY_W-1:0] start_c  = (best == '0) ? best : best - 8'h01;

  // search falling-edge alignment: coarse both polarities, then fine
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= CAL_IDLE;
      inv_r     <= 1'b0;
      coarse_r  <= '0;
      fine_r    <= '0;
      found_n_r <= '0;
      settle_r  <= 8'h00;
      done_r    <= 1'b0;
    end else begin
      if (sysref_rise)  // settle counts skipped sysref edges, not cycles
        settle_r <= settled ? cfg_r : settle_r - 8'h01;
      case (state_r)
        CAL_IDLE: begin
          if (cal_en_r) begin  // R13
            state_r  <= CAL_COARSE;
            inv_r    <= 1'b0;
            coarse_r <= '0;
            fine_r   <= '0;
            done_r   <= 1'b0;
            settle_r <= cfg_r;
          end
        end
        CAL_COARSE: begin
          if (!cal_en_r) begin
            state_r <= CAL_IDLE;
          end else if (step && (phase_late || top)) begin
            if (!inv_r) begin  // R14
              found_n_r <= coarse_r;
              inv_r     <= 1'b1;
              coarse_r  <= '0;
            end else begin
              inv_r    <= pick_inv;
              coarse_r <= start_c;
              state_r  <= CAL_FINE;
            end
          end else if (step) begin
            coarse_r <= coarse_r + 8'h01;  // R13
          end
        end
        CAL_FINE: begin
          if (!cal_en_r) begin
            state_r <= CAL_IDLE;
          end else if (hit || (step && fine_r == '1)) begin
            state_r <= CAL_DONE;
            done_r  <= 1'b1;  // R15
          end else if (step) begin
            fine_r <= fine_r + 8'h01;
          end
        end
        CAL_DONE: begin
          if (!cal_en_r)
            state_r <= CAL_IDLE;
        end
        default: state_r <= CAL_IDLE;
      endcase
    end
  end

  // calibrated setting holds until software disables calibration and writes its own delay
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      use_cal_r <= 1'b0;
    else if (state_r == CAL_FINE && done_r == 1'b0 && cal_en_r)
      use_cal_r <= 1'b1;
    else if (wr_tad && !cal_en_r)
      use_cal_r <= 1'b0;  // R16
  end

  wire searching = state_r == CAL_COARSE || state_r == CAL_FINE;
  wire drive_cal = searching || use_cal_r;  // R16

  // delay controls combine independently in the clock path
  assign clock_polarity_invert = drive_cal ? inv_r : tad_sw_r[CLOCK_POLARITY_INVERT_BIT];  // R19
  assign aperture_delay_coarse = drive_cal ? coarse_r : tad_sw_r[15:8];
  assign aperture_delay_fine   = drive_cal ? fine_r : tad_sw_r[7:0];

  // ---------------- read path ----------------
  wire [31:0] cal_stat = {6'h00, map_valid, done_r, 7'h00, inv_r, coarse_r, fine_r};
  wire [31:0] rd_mux =
    (ar_idx == IDX_CTRL)     ? {27'h0, zoom_r, sel_r} :
    (ar_idx == IDX_TAD)      ? {15'h0, tad_sw_r} :
    (ar_idx == IDX_MAP_LO)   ? {24'h0, map[7:0]} :    // R20
    (ar_idx == IDX_MAP_MID)  ? {24'h0, map[15:8]} :
    (ar_idx == IDX_MAP_HI)   ? {24'h0, map[23:16]} :
    (ar_idx == IDX_CAL_EN)   ? {31'h0, cal_en_r} :
    (ar_idx == IDX_CAL_CFG)  ? {24'h0, cfg_r} :
    (ar_idx == IDX_CAL_STAT) ? cal_stat : 32'h0000_0000;  // R15
  wire rd_hit = ar_idx == IDX_CTRL || ar_idx == IDX_TAD ||
                ar_idx == IDX_MAP_LO || ar_idx == IDX_MAP_MID ||
                ar_idx == IDX_MAP_HI || ar_idx == IDX_CAL_EN ||
                ar_idx == IDX_CAL_CFG || ar_idx == IDX_CAL_STAT;

  // read answer one cycle after address is taken
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (do_read) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_last_edge;
    sysref_rise && edge_cnt_r == 2'h2;
  endsequence

  property p_map_ends;
    map[0] && map[MAP_W-1];
  endproperty
  a_map_ends: assert property (p_map_ends) else $error("map end bits not set"); // R5

  property p_valid_third;
    $rose(map_valid) |-> $past(sysref_rise) && $past(edge_cnt_r) == 2'h2;
  endproperty
  a_valid_third: assert property (p_valid_third) else $error("map valid too early"); // R2

  property p_valid_after;
    s_last_edge and !wr_ctrl |=> map_valid;
  endproperty
  a_valid_after: assert property (p_valid_after) else $error("map not valid on third edge"); // R2

  property p_capture;
    ##1 sysref_captured == $past(tap_sample[sel_r]);
  endproperty
  a_capture: assert property (p_capture) else $error("wrong capture tap"); // R6

  property p_viol;
    sysref_rise && !wr_ctrl && tap_sample[5] != tap_sample[4] |=> map[5] && map[4];
  endproperty
  a_viol: assert property (p_viol) else $error("marginal tap not flagged"); // R3

  property p_done_result;
    $rose(done_r) |-> cal_stat[16:0] == {clock_polarity_invert,
                      aperture_delay_coarse, aperture_delay_fine} &&
                      (phase_late || aperture_delay_fine == '1);
  endproperty
  a_done_result: assert property (p_done_result) else $error("result not applied"); // R15

  property p_hold;
    use_cal_r && state_r == CAL_DONE && !wr_tad |=>
      $stable(aperture_delay_coarse) && $stable(clock_polarity_invert);
  endproperty
  a_hold: assert property (p_hold) else $error("calibrated delay drifted"); // R16

  property p_step;
    state_r == CAL_COARSE && cal_en_r && step && !phase_late && !top
      |=> coarse_r == $past(coarse_r) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("coarse search stalled"); // R13

  property p_pick;
    state_r == CAL_COARSE && $past(state_r) == CAL_COARSE && inv_r ##1
      state_r == CAL_FINE |-> coarse_r <= found_n_r;
  endproperty
  a_pick: assert property (p_pick) else $error("larger coarse kept"); // R14

endmodule
`default_nettype wire
